// ### hw/bco_close_out.sv
/*
 * Breaker close latch, close failure timer, four pulsed output contacts, alarm coil,
 * and the APB register file; the target store is a submodule.
 * Assumes equation inputs come from logic on pclk; the lamp button and contact jumpers are pins.
 */
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module bco_close_out
#(
    parameter int PROC_CYC = bco_pkg::PROC_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control equations
    input wire logic close_condition_eq,
    input wire logic close_unlatch_eq,
    input wire logic breaker_status_eq,
    input wire logic [3:0] output_eq,
    input wire logic access_lvl2,
    input wire logic relay_enabled,
    // Protection elements
    input wire logic trip_event,
    input wire logic [5:0] diff_elem,
    input wire logic [12:0] inst_elem,
    input wire logic [5:0] toc_elem,
    input wire logic [2:0] phase_over,
    // Pins
    input wire logic lamp_test_btn,
    input wire logic [3:0] contact_type_b,
    // Nonvolatile target storage
    input wire logic [6:0] nv_data_in,
    output logic [6:0] nv_data_out,
    // Close and output contacts
    output logic close_out,
    output logic close_fail_flag,
    output logic [3:0] output_bit_n,
    output logic [3:0] out_coil,
    output logic [3:0] contact_closed,
    output logic alarm_bit,
    output logic alarm_coil,
    output logic alarm_contact_closed,
    output logic [7:0] led
);
    import bco_pkg::*;

    if (PROC_CYC < 2)
    begin : bad_div
        $error("PROC_CYC must be at least 2");
    end

    bco_tgt_if tl();

    logic [31:0] div_cnt;
    logic tick;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_s3;
    logic [4:0] pin_stab;
    logic lamp_prev;
    logic cold;
    logic [1:0] ctrl;
    logic [15:0] fail_dly;
    logic wr_en;
    logic cmd_close_set;
    logic [3:0] pulse_set;
    logic alarm_set;
    logic cmd_close_pend;
    logic [3:0] pulse_pend;
    logic [MOM_W-1:0] pulse_cnt [4];
    logic alarm_pend;
    logic [MOM_W-1:0] alarm_cnt;
    logic lvl2_prev;
    logic cond_prev;
    logic [FAIL_W-1:0] fail_cnt;
    logic [FAIL_W-1:0] fail_limit;
    logic fail_hit;
    logic set_req;
    logic permit;
    logic [3:0] next_out;
    logic next_alarm;

    function automatic logic [FAIL_W-1:0] cyc2ticks(input logic [15:0] cyc);
        return FAIL_W'(cyc) * FAIL_W'(TICKS_PER_CYC);
    endfunction

    // Processing interval enable; all relay logic except the lamp test start and the cold-start restore steps on this pulse. [RL20]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (div_cnt == 32'(PROC_CYC - 1));
            div_cnt <= (div_cnt == 32'(PROC_CYC - 1)) ? '0 : div_cnt + 32'h1;
        end
    end

    // Pin inputs pass three flops; a bit moves only when the second and third agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
            pin_s3 <= 5'h00;
            pin_stab <= 5'h00;
            lamp_prev <= 1'b0;
        end
        else
        begin
            pin_s1 <= {lamp_test_btn, contact_type_b};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_stab <= (pin_s2 & pin_s3) | (pin_stab & (pin_s2 | pin_s3));
            lamp_prev <= pin_stab[4];
        end
    end

    // APB: one wait state, so pready is a flop and data are ready with it.
    assign wr_en = psel & penable & pready & pwrite;
    assign cmd_close_set = wr_en && paddr == CMD_OFS && pwdata[CMD_CLOSE];
    assign pulse_set = (wr_en && paddr == CMD_OFS) ? pwdata[CMD_PULSE +: 4] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready)
            begin
                pslverr <= !(paddr == CTRL_OFS || paddr == FDLY_OFS || paddr == CMD_OFS || paddr == STAT_OFS);
                unique case (paddr)
                    CTRL_OFS: prdata <= {30'h0, ctrl};
                    FDLY_OFS: prdata <= {16'h0, fail_dly};
                    STAT_OFS: prdata <= {17'h0, tl.targets, tl.lamp_on, alarm_bit, output_bit_n,
                        close_fail_flag, close_out};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RST;
            fail_dly <= FDLY_RST;
        end
        else if (wr_en && paddr == CTRL_OFS)
        begin
            ctrl <= pwdata[1:0];
        end
        else if (wr_en && paddr == FDLY_OFS)
        begin
            fail_dly <= pwdata[15:0];
        end
    end

    // Command and level-2 requests wait for the next tick; a new request beats the clear.
    assign alarm_set = (wr_en && paddr == CMD_OFS && pwdata[CMD_ALARM]) || (access_lvl2 && !lvl2_prev);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_close_pend <= 1'b0;
            pulse_pend <= 4'h0;
            alarm_pend <= 1'b0;
            lvl2_prev <= 1'b0;
        end
        else
        begin
            lvl2_prev <= access_lvl2;
            cmd_close_pend <= (cmd_close_pend & ~tick) | cmd_close_set;
            pulse_pend <= (pulse_pend & ~{4{tick}}) | pulse_set;
            alarm_pend <= (alarm_pend & ~tick) | alarm_set; // [RL14]
        end
    end

    always_comb
    begin
        fail_limit = cyc2ticks(fail_dly);
        fail_hit = (fail_dly != 16'h0000) && close_out && (fail_cnt >= fail_limit - FAIL_W'(1)); // [RL5] [RL6]
        set_req = (close_condition_eq & ~cond_prev) | (cmd_close_pend & ctrl[CTRL_SCMD]); // [RL2] [RL3]
        permit = ~close_unlatch_eq & ~breaker_status_eq & ~close_fail_flag & ~ctrl[CTRL_INOP]; // [RL1]
    end

    // Close latch; the inoperable control bit ctrl[CTRL_INOP] makes the whole close path dead.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            close_out <= 1'b0;
            close_fail_flag <= 1'b0;
            cond_prev <= 1'b0;
            fail_cnt <= '0;
        end
        else if (tick)
        begin
            cond_prev <= close_condition_eq;
            close_fail_flag <= fail_hit; // [RL5]
            fail_cnt <= close_out ? fail_cnt + FAIL_W'(1) : '0;
            if (ctrl[CTRL_INOP])
            begin
                close_out <= 1'b0; // [RL7]
            end
            else if (close_out)
            begin
                if (close_unlatch_eq || breaker_status_eq || fail_hit)
                begin
                    close_out <= 1'b0; // [RL4]
                end
            end
            else if (permit && set_req)
            begin
                close_out <= 1'b1; // [RL1] [RL2] [RL3]
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            next_out[i] = output_eq[i] | pulse_pend[i] | (pulse_cnt[i] != '0); // [RL8] [RL9]
        end
        next_alarm = alarm_pend | (alarm_cnt != '0); // [RL13]
    end

    // Pulse timers hold a commanded bit for one power cycle of ticks plus the tick that loads them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                pulse_cnt[i] <= '0;
            end
            alarm_cnt <= '0;
        end
        else if (tick)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (pulse_pend[i])
                begin
                    pulse_cnt[i] <= MOM_W'(MOM_TICKS);
                end
                else if (pulse_cnt[i] != '0)
                begin
                    pulse_cnt[i] <= pulse_cnt[i] - MOM_W'(1);
                end
            end
            if (alarm_pend)
            begin
                alarm_cnt <= MOM_W'(MOM_TICKS);
            end
            else if (alarm_cnt != '0)
            begin
                alarm_cnt <= alarm_cnt - MOM_W'(1);
            end
        end
    end

    // The alarm coil resets energised so a b-type alarm contact stays open in service.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_bit_n <= 4'h0;
            out_coil <= 4'h0;
            alarm_bit <= 1'b0;
            alarm_coil <= 1'b1;
        end
        else if (tick)
        begin
            output_bit_n <= next_out; // [RL8]
            out_coil <= next_out; // [RL10]
            alarm_bit <= next_alarm; // [RL13]
            alarm_coil <= ~next_alarm; // [RL12] [RL14]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            contact_closed <= 4'h0;
            alarm_contact_closed <= 1'b0;
            led <= 8'h00;
            nv_data_out <= 7'h00;
            cold <= 1'b1;
        end
        else
        begin
            contact_closed <= out_coil ^ pin_stab[3:0]; // [RL11]
            alarm_contact_closed <= ~alarm_coil; // [RL12]
            led <= tl.lamp_on ? 8'hFF : {relay_enabled, tl.targets}; // [RL19]
            nv_data_out <= tl.targets; // [RL18]
            cold <= 1'b0;
        end
    end

    assign tl.tick = tick;
    assign tl.trip_event = trip_event;
    assign tl.diff_elem = diff_elem;
    assign tl.inst_elem = inst_elem;
    assign tl.toc_elem = toc_elem;
    assign tl.phase_over = phase_over;
    assign tl.lamp_press = pin_stab[4] & ~lamp_prev;
    assign tl.nv_load = cold; // [RL18]
    assign tl.nv_data = nv_data_in;

    bco_targets u_tgt (
        .pclk(pclk),
        .presetn(presetn),
        .t(tl.tgt)
    );

    sequence close_rise_s;
        tick && !close_out && permit && set_req && !ctrl[CTRL_INOP];
    endsequence

    set_permit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
        $rose(close_out) |-> $past(permit) && $past(tick))
        else $error("close set while not permitted");
    level_only_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
        tick && !close_out && cond_prev && !cmd_close_pend |=> !close_out)
        else $error("steady close condition retriggered close");
    close_set_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
        close_rise_s |=> close_out)
        else $error("permitted close request ignored");
    close_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
        tick && close_out && (close_unlatch_eq || breaker_status_eq) |=> !close_out)
        else $error("close not unlatched");
    fail_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL5]
        close_out && fail_dly != 16'h0000 |-> fail_cnt < fail_limit)
        else $error("close outlived failure delay");
    no_timer_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
        tick && fail_dly == 16'h0000 |=> !close_fail_flag)
        else $error("failure flag with timer off");
    inop_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
        tick && ctrl[CTRL_INOP] |=> !close_out)
        else $error("close active while inoperable");
    out_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
        tick && (pulse_pend != 4'h0) |=> ((output_bit_n & $past(pulse_pend)) == $past(pulse_pend))
        && out_coil == output_bit_n)
        else $error("pulse did not assert output");
    contact_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL11]
        ##1 contact_closed == $past(out_coil ^ pin_stab[3:0]))
        else $error("contact state wrong for type");
    alarm_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL13]
        tick && alarm_pend |=> (alarm_bit && !alarm_coil)[*8])
        else $error("alarm pulse wrong");
endmodule

// ### hw/bco_pkg.sv
/*
 * Constants for the breaker close and output logic: register map, field positions,
 * element indices and timing counts.
 * Assumes a 10 MHz pclk and a relay processing interval of a quarter power-system cycle.
 */
// Contract
// [RL1] Close sets only if unlatch low, breaker open, no failure.
// [RL2] Close condition rising edge sets close; level does not.
// [RL3] Serial close command sets close when included.
// [RL4] Close holds until unlatch, breaker closed, or failure.
// [RL5] Failure flag after delay; close lasts at most delay.
// [RL6] Zero delay disables the close failure timer.
// [RL7] Breaker status tied to zero disables close logic; the code disables it with the ctrl[CTRL_INOP] bit instead.
// [RL8] Each output equation drives its own output bit.
// [RL9] Pulse command asserts named output bit too.
// [RL10] Asserted output bit energises matching coil.
// [RL11] Contact state follows jumper type a or b.
// [RL12] Alarm coil stays energised in normal operation.
// [RL13] Pulse alarm drops coil, raises alarm bit momentarily.
// [RL14] Entering access level 2 pulses the alarm.
// [RL15] Targets update on a trip event.
// [RL16] Group targets light when any group element asserts.
// [RL17] Phase target lights on phase element or overcurrent.
// [RL18] Targets kept nonvolatile and restored at cold start.
// [RL19] Lamp test lights all one second, clears faults.
// [RL20] Logic evaluated once per processing interval tick.
package bco_pkg;
    localparam int CLK_MHZ = 10;
    localparam int PROC_US = 4167;
    localparam int PROC_CYC = PROC_US * CLK_MHZ;
    localparam int TICKS_PER_CYC = 4;
    localparam int LAMP_MS = 1000;
    localparam int LAMP_TICKS = (LAMP_MS * 1000 + PROC_US - 1) / PROC_US;
    localparam int MOM_CYC = 1;
    localparam int MOM_TICKS = MOM_CYC * TICKS_PER_CYC;
    localparam int MOM_W = 3;
    localparam int LAMP_W = 8;
    localparam int FAIL_W = 18;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FDLY_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] FDLY_RST = 16'h0000;
    localparam int CTRL_INOP = 0;
    localparam int CTRL_SCMD = 1;
    localparam int CMD_CLOSE = 0;
    localparam int CMD_PULSE = 1;
    localparam int CMD_ALARM = 5;
    localparam int STAT_TGT = 8;
    // Target bit order: differential, instantaneous, timed, A, B, C, ground.
    localparam int TGT_87 = 0;
    localparam int TGT_50 = 1;
    localparam int TGT_51 = 2;
    localparam int TGT_A = 3;
    localparam int TGT_G = 6;
    // Instantaneous element indices: P1..P3, A1, A2, B1, B2, C1, C2, Q1, Q2, G1, G2.
    localparam int INST_A1 = 3;
    localparam int INST_G1 = 11;
    // Timed element indices: PT, AT, BT, CT, QT, GT.
    localparam int TOC_PT = 0;
    localparam int TOC_AT = 1;
    localparam int TOC_GT = 5;
endpackage

// ### hw/bco_tgt_if.sv
/*
 * Link between the close and output logic and its target indicator store.
 * Assumes both ends share pclk.
 */
`timescale 1ns/10ps
interface bco_tgt_if;
    logic tick;
    logic trip_event;
    logic [5:0] diff_elem;
    logic [12:0] inst_elem;
    logic [5:0] toc_elem;
    logic [2:0] phase_over;
    logic lamp_press;
    logic nv_load;
    logic [6:0] nv_data;
    logic [6:0] targets;
    logic lamp_on;
    modport src (output tick, trip_event, diff_elem, inst_elem, toc_elem, phase_over, lamp_press,
        nv_load, nv_data, input targets, lamp_on);
    modport tgt (input tick, trip_event, diff_elem, inst_elem, toc_elem, phase_over, lamp_press,
        nv_load, nv_data, output targets, lamp_on);
endinterface

// ### hw/bco_targets.sv
/*
 * Front-panel fault target latch with lamp test and cold-start restore.
 * Assumes element inputs are from logic on pclk and the press is already synchronised.
 */
`timescale 1ns/10ps
module bco_targets
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the close and output logic
    bco_tgt_if.tgt t
);
    import bco_pkg::*;

    typedef enum logic {BCO_LAMP_IDLE, BCO_LAMP_ON} bco_lamp_e;

    bco_lamp_e lamp_state;
    logic [LAMP_W-1:0] lamp_cnt;
    logic [6:0] hit;

    function automatic logic phase_tgt(input int ph);
        logic ovr;
        ovr = t.toc_elem[TOC_PT] | (|t.inst_elem[2:0]);
        return (ovr & t.phase_over[ph]) | (|t.diff_elem[2*ph +: 2]) | (|t.inst_elem[INST_A1 + 2*ph +: 2])
            | t.toc_elem[TOC_AT + ph];
    endfunction

    always_comb
    begin
        hit[TGT_87] = |t.diff_elem; // [RL16]
        hit[TGT_50] = |t.inst_elem;
        hit[TGT_51] = |t.toc_elem;
        hit[TGT_G] = (|t.inst_elem[INST_G1 +: 2]) | t.toc_elem[TOC_GT];
        for (int p = 0; p < 3; p++)
        begin
            hit[TGT_A + p] = phase_tgt(p); // [RL17]
        end
    end

    // A lamp test in progress still lets a trip record, but the clear at the end wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t.targets <= 7'h00;
        end
        else if (t.nv_load)
        begin
            t.targets <= t.nv_data; // [RL18]
        end
        else if (t.tick && lamp_state == BCO_LAMP_ON && lamp_cnt == '0)
        begin
            t.targets <= 7'h00; // [RL19]
        end
        else if (t.tick && t.trip_event)
        begin
            t.targets <= t.targets | hit; // [RL15]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lamp_state <= BCO_LAMP_IDLE;
            lamp_cnt <= '0;
        end
        else
        begin
            unique case (lamp_state)
                BCO_LAMP_IDLE:
                begin
                    if (t.lamp_press)
                    begin
                        lamp_state <= BCO_LAMP_ON;
                        lamp_cnt <= LAMP_W'(LAMP_TICKS - 1); // [RL19]
                    end
                end
                BCO_LAMP_ON:
                begin
                    if (t.tick)
                    begin
                        if (lamp_cnt == '0)
                        begin
                            lamp_state <= BCO_LAMP_IDLE;
                        end
                        else
                        begin
                            lamp_cnt <= lamp_cnt - LAMP_W'(1);
                        end
                    end
                end
            endcase
        end
    end

    assign t.lamp_on = (lamp_state == BCO_LAMP_ON);

    lamp_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL19]
        t.tick && lamp_state == BCO_LAMP_ON && lamp_cnt == '0 && !t.nv_load |=> t.targets == 7'h00 && !t.lamp_on)
        else $error("targets not cleared at end of lamp test");
endmodule

// ### sim/bco_breaker_model.sv
/*
 * Circuit breaker auxiliary contact model for the close logic bench.
 * Assumes close_out comes from the design on pclk and the bench drives respond and trip.
 */
`timescale 1ns/10ps
module bco_breaker_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Close coil and bench controls
    input wire logic close_out,
    input wire logic respond,
    input wire logic trip,
    // Auxiliary contact
    output logic breaker_status_eq
);
    // A slow breaker ignores close_out entirely, so the close failure timer must end it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            breaker_status_eq <= 1'b0;
        else if (trip)
            breaker_status_eq <= 1'b0;
        else if (respond && close_out)
            breaker_status_eq <= 1'b1;
    end
endmodule

// ### sim/breaker_close_output_logic_test.sv
/*
 * Self-checking bench for the breaker close and output logic.
 * Assumes a short processing interval of 4 pclk cycles and the breaker model beside it.
 */
`timescale 1ns/10ps
module breaker_close_output_logic_test;
    import bco_pkg::*;
    localparam int PC = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, cond = 1'b0, ul = 1'b0, bs, al2 = 1'b0, respond = 1'b0, trip = 1'b0;
    logic [3:0] oeq = 4'h0, ctb = 4'h0, obit, coil, cclosed;
    logic tev = 1'b0, lamp = 1'b0, fflag, cls, abit, acoil, acl;
    logic [5:0] de = 6'h00, te = 6'h00;
    logic [12:0] ie = 13'h0000;
    logic [2:0] po = 3'h0;
    logic [6:0] nvo;
    logic [7:0] led;
    int n_errors = 0, num_checks = 0, seed = 32'hD9CE7777, n, i;
    always #50 pclk = ~pclk;
    bco_close_out #(.PROC_CYC(PC)) bco_close_out_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .close_condition_eq(cond), .close_unlatch_eq(ul), .breaker_status_eq(bs),
        .output_eq(oeq), .access_lvl2(al2), .relay_enabled(1'b1), .trip_event(tev), .diff_elem(de),
        .inst_elem(ie), .toc_elem(te), .phase_over(po), .lamp_test_btn(lamp), .contact_type_b(ctb),
        .nv_data_in(7'h55), .nv_data_out(nvo), .close_out(cls), .close_fail_flag(fflag), .output_bit_n(obit),
        .out_coil(coil), .contact_closed(cclosed), .alarm_bit(abit), .alarm_coil(acoil),
        .alarm_contact_closed(acl), .led(led));
    bco_breaker_model bco_breaker_model_inst (.pclk(pclk), .presetn(presetn), .close_out(cls),
        .respond(respond), .trip(trip), .breaker_status_eq(bs));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tk(input int t);
        repeat (t * PC) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for a slave that never answers.
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Fault targets worked out from the element groups and phase currents.
    function automatic logic [6:0] tgt(logic [5:0] d, logic [12:0] i, logic [5:0] t, logic [2:0] p);
        logic ph;
        ph = t[0] | (|i[2:0]);
        return {i[11] | i[12] | t[5], d[4] | d[5] | i[7] | i[8] | t[3] | (ph & p[2]),
            d[2] | d[3] | i[5] | i[6] | t[2] | (ph & p[1]), d[0] | d[1] | i[3] | i[4] | t[1] | (ph & p[0]),
            |t, |i, |d};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("restored led", led, 8'hD5);
        chk("alarm coil", {abit, acoil}, 2'b01);
        apb(1'b0, FDLY_OFS, 0);
        chk("delay reset", q, 32'h0);
        apb(1'b0, 8'h40, 0);
        chk("unmapped error", e, 1'b1);
        apb(1'b1, FDLY_OFS, 32'h1);
        cond <= 1'b1;
        n = 0;
        e = 1'b0;
        repeat (30 * PC)
        begin
            @(posedge pclk);
            n += cls;
            e |= fflag;
        end
        chk("close length", n, 1 * TICKS_PER_CYC * PC);
        chk("fail flag seen", e, 1'b1);
        chk("no retrigger", cls, 1'b0);
        apb(1'b1, FDLY_OFS, 32'h0);
        cond <= 1'b0;
        ul <= 1'b1;
        tk(2);
        cond <= 1'b1;
        tk(3);
        chk("unlatch blocks", cls, 1'b0);
        ul <= 1'b0;
        cond <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h3);
        tk(2);
        cond <= 1'b1;
        tk(3);
        chk("inoperable", cls, 1'b0);
        cond <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h2);
        apb(1'b1, CMD_OFS, 32'h1);
        tk(3);
        chk("serial close", cls, 1'b1);
        tk(20);
        chk("no fail timer", cls, 1'b1);
        respond <= 1'b1;
        tk(3);
        chk("breaker closed ends", cls, 1'b0);
        trip <= 1'b1;
        respond <= 1'b0;
        tk(1);
        trip <= 1'b0;
        for (i = 0; i < 8; i++)
        begin
            oeq <= 4'($random(seed));
            ctb <= 4'($random(seed));
            tk(3);
            chk("output bits", obit, oeq);
            chk("coils", coil, oeq);
            chk("contacts", cclosed, oeq ^ ctb);
        end
        oeq <= 4'h0;
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, CMD_OFS, 32'h1 << (i + 1));
            tk(2);
            chk("pulsed output", obit, 4'h1 << i);
            tk(6);
        end
        for (i = 0; i < 2; i++)
        begin
            if (i == 0)
                apb(1'b1, CMD_OFS, 32'h20);
            else
                al2 <= 1'b1;
            tk(2);
            chk("alarm pulse", {abit, acoil, acl}, 3'b101);
            tk(6);
            chk("alarm rest", {abit, acoil}, 2'b01);
        end
        for (i = 0; i < 3; i++)
        begin
            lamp <= 1'b1;
            tk(2);
            chk("lamp on", led, 8'hFF);
            lamp <= 1'b0;
            tk(LAMP_TICKS + 4);
            chk("lamp cleared", led, 8'h80);
            de <= 6'($random(seed));
            ie <= 13'($random(seed));
            te <= 6'($random(seed));
            po <= 3'($random(seed));
            tev <= 1'b1;
            tk(2);
            chk("targets", led[6:0], tgt(de, ie, te, po));
            chk("stored targets", nvo, tgt(de, ie, te, po));
            tev <= 1'b0;
            de <= 6'h00;
            ie <= 13'h0000;
            te <= 6'h00;
        end
        report_and_stop();
    end
endmodule
